// ### design/swr_pkg.sv
// Purpose: Constants for the selective-wake bit recovery setup block
// Assumes: 50 MHz system clock, classic Wishbone register access
// Notes: Register map, field positions, reset values and timing counts
// How it works
// RULE1 - Host turns transceiver off (mode 000) with recovery disabled before setup.
// RULE2 - Host programs the two-bit recovery clock select second.
// RULE3 - Host writes bit quanta and upper/lower limits for the baud rate third.
// RULE4 - Host picks filter settings and sets recovery enable last.
// RULE5 - Reaching a limit discards all accumulated timing measurements.
// RULE6 - After a discard the programmed bit quanta is reloaded as estimate.
// RULE7 - On baud change host updates clock select and bit quanta, even disabled.
// RULE8 - Host rewrites limits when baud rate or recovery clock changes.
// RULE9 - Host clears enable before editing recovery registers, sets it afterwards.
// RULE10 - Sample point register should stay at default 11 0011, about 80 percent.
// RULE11 - Bus declared inactive after silence between 0.6 and 1.2 seconds.
// RULE12 - Wake pattern or frame answered within 100 microseconds.
// RULE13 - Wake shown by interrupt in stop mode, regulator ramp in sleep mode.
// RULE14 - Decoding supports bit times down to 1 microsecond, 1 Mbit/s.
// RULE15 - While enabled, bus bits are measured and the decode clock corrected.
// RULE16 - Bit quanta register sets quanta per bit, relative to selected clock.
// RULE17 - Silence timer restarts on every bus edge, expires only after full interval.
package swr_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h04;
  localparam logic [7:0] ADDR_CTRL_TWO = 8'h08;
  localparam logic [7:0] ADDR_QUANTA = 8'h0C;
  localparam logic [7:0] ADDR_SAMPLE = 8'h10;
  localparam logic [7:0] ADDR_UPPER = 8'h14;
  localparam logic [7:0] ADDR_LOWER = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;
  localparam logic [7:0] ADDR_MASK = 8'h20;
  localparam logic [7:0] ADDR_ESTIMATE = 8'h24;
  localparam logic [7:0] ADDR_WAKECMD = 8'h28;
  // ==========================================================
  // Field positions
  localparam int ENABLE_BIT = 0;
  localparam int FILTER_LSB = 1;
  localparam int FILTER_W = 2;
  localparam int ST_WAKE = 0;
  localparam int ST_SILENCE = 1;
  localparam int ST_LIMIT = 2;
  localparam int NUM_EVT = 3;
  localparam int CMD_PATTERN = 0;
  localparam int CMD_FRAME = 1;
  // ==========================================================
  // Reset values
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [5:0] SAMPLE_RST = 6'h33;
  localparam logic [7:0] QUANTA_RST = 8'h28;
  localparam logic [7:0] UPPER_RST = 8'h30;
  localparam logic [7:0] LOWER_RST = 8'h20;
  // Power modes of the chip
  localparam logic [1:0] PM_NORMAL = 2'h0;
  localparam logic [1:0] PM_STOP = 2'h1;
  localparam logic [1:0] PM_SLEEP = 2'h2;
  // ==========================================================
  // Timing
  localparam int CLK_HZ = 50_000_000;
  localparam int SILENCE_MIN_MS = 600;
  localparam int SILENCE_MAX_MS = 1200;
  // Middle of the window, safe against oscillator spread
  localparam int SILENCE_MS = (SILENCE_MIN_MS + SILENCE_MAX_MS) / 2;
  localparam int SILENCE_CYC = (CLK_HZ / 1000) * SILENCE_MS;
  localparam int WAKE_MAX_US = 100;
  localparam int WAKE_CYC = (CLK_HZ / 1_000_000) * WAKE_MAX_US;
  localparam int WAKE_DELAY_CYC = 2;
  localparam int BIT_MIN_US = 1;
  localparam int BIT_MIN_CYC = ((CLK_HZ / 1_000_000) * BIT_MIN_US);
endpackage : swr_pkg

// ### design/swr_top.sv
// Purpose: Bit recovery and partial network timing for a CAN selective-wake receiver
// Assumes: bus_rx_i synchronous to clk_i; wake detection made elsewhere
// Notes: Registers over classic Wishbone; one level interrupt output
`timescale 1ns/1ns
module swr_top #(
  parameter int SILENCE_CYCLES = swr_pkg::SILENCE_CYC,
  parameter int CNT_W = 26
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic bus_rx_i,
  input wire logic [1:0] power_mode_i,
  input wire logic wake_pattern_i,
  input wire logic wake_frame_i,
  output logic irq_o,
  output logic wake_int_o,
  output logic main_regulator_output_o,
  output logic bus_idle_o,
  output logic [2:0] transceiver_mode_o,
  output logic [7:0] bit_estimate_o
);
  import swr_pkg::*;

  // ==========================================================
  // Register file
  logic [2:0] mode_r;
  logic [2:0] recovery_control_one_r;
  logic [1:0] recovery_clock_select_r;
  logic [7:0] bit_quanta_control_r;
  logic [5:0] sample_point_control_r;
  logic [7:0] recovery_upper_limit_r;
  logic [7:0] recovery_lower_limit_r;
  logic [NUM_EVT-1:0] status_r;
  logic [NUM_EVT-1:0] mask_r;
  logic [31:0] rdata_nxt;

  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr_lo = bus_req & wb_we_i & wb_sel_i[0];
  wire wr_mode = wr_lo & (wb_adr_i == ADDR_MODE);
  wire wr_c1 = wr_lo & (wb_adr_i == ADDR_CTRL_ONE);
  wire wr_c2 = wr_lo & (wb_adr_i == ADDR_CTRL_TWO);
  wire wr_q = wr_lo & (wb_adr_i == ADDR_QUANTA);
  wire wr_sp = wr_lo & (wb_adr_i == ADDR_SAMPLE);
  wire wr_up = wr_lo & (wb_adr_i == ADDR_UPPER);
  wire wr_lw = wr_lo & (wb_adr_i == ADDR_LOWER);
  wire wr_st = wr_lo & (wb_adr_i == ADDR_STATUS);
  wire wr_mk = wr_lo & (wb_adr_i == ADDR_MASK);
  wire wr_cmd = wr_lo & (wb_adr_i == ADDR_WAKECMD);
  wire recovery_enable = recovery_control_one_r[ENABLE_BIT];
  wire [FILTER_W-1:0] filter_sel = recovery_control_one_r[FILTER_LSB +: FILTER_W];

  // Read mux, unmapped offsets read zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (wb_adr_i)
      ADDR_MODE: rdata_nxt[2:0] = mode_r;
      ADDR_CTRL_ONE: rdata_nxt[2:0] = recovery_control_one_r;
      ADDR_CTRL_TWO: rdata_nxt[1:0] = recovery_clock_select_r;
      ADDR_QUANTA: rdata_nxt[7:0] = bit_quanta_control_r;
      ADDR_SAMPLE: rdata_nxt[5:0] = sample_point_control_r;
      ADDR_UPPER: rdata_nxt[7:0] = recovery_upper_limit_r;
      ADDR_LOWER: rdata_nxt[7:0] = recovery_lower_limit_r;
      ADDR_STATUS: rdata_nxt[NUM_EVT-1:0] = status_r;
      ADDR_MASK: rdata_nxt[NUM_EVT-1:0] = mask_r;
      ADDR_ESTIMATE: rdata_nxt[7:0] = bit_estimate_o;
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Single cycle answer, ack drops the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rdata_nxt : 32'h0000_0000;
    end
  end

  // Configuration registers; host owns the setup order
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= MODE_OFF; // RULE1
      recovery_control_one_r <= 3'h0;
      recovery_clock_select_r <= 2'h0;
      bit_quanta_control_r <= QUANTA_RST;
      sample_point_control_r <= SAMPLE_RST; // RULE10
      recovery_upper_limit_r <= UPPER_RST;
      recovery_lower_limit_r <= LOWER_RST;
      mask_r <= {NUM_EVT{1'b0}};
    end else begin
      if (wr_mode) mode_r <= wb_dat_i[2:0];
      if (wr_c1) recovery_control_one_r <= wb_dat_i[2:0]; // RULE4
      if (wr_c2) recovery_clock_select_r <= wb_dat_i[1:0]; // RULE2
      if (wr_q) bit_quanta_control_r <= wb_dat_i[7:0]; // RULE3
      if (wr_sp) sample_point_control_r <= wb_dat_i[5:0];
      if (wr_up) recovery_upper_limit_r <= wb_dat_i[7:0]; // RULE8
      if (wr_lw) recovery_lower_limit_r <= wb_dat_i[7:0];
      if (wr_mk) mask_r <= wb_dat_i[NUM_EVT-1:0];
    end
  end

  // ==========================================================
  // Bus edge detect and bit length measurement
  logic rx_d_r;
  logic [7:0] bit_cnt_r;
  logic [7:0] bit_cnt_nxt;
  logic [1:0] presc_r;
  logic [9:0] acc_r;
  logic [1:0] acc_n_r;
  logic limit_evt;
  logic [7:0] est_nxt;
  wire bus_edge = bus_rx_i ^ rx_d_r;
  // Sum includes the bit ending now, so the fourth edge averages four full bits
  wire [9:0] acc_sum = acc_r + {2'h0, bit_cnt_r};
  // Quanta tick rate follows the recovery clock select
  wire q_tick = (presc_r == recovery_clock_select_r); // RULE16

  // Running average over four bits, filter selects the step size
  function automatic logic [7:0] swr_blend(input logic [7:0] old_v,
                                            input logic [7:0] avg_v,
                                            input logic [1:0] sh);
    logic [8:0] diff;
    diff = {1'b0, avg_v} - {1'b0, old_v};
    swr_blend = old_v + 8'(($signed(diff)) >>> sh);
  endfunction

  assign bit_cnt_nxt = (bit_cnt_r == 8'hFF) ? bit_cnt_r : bit_cnt_r + 8'h01;
  // Limit hit means the acquired timing is untrustworthy
  assign limit_evt = recovery_enable & bus_edge &
                     ((bit_cnt_r >= recovery_upper_limit_r) |
                      (bit_cnt_r <= recovery_lower_limit_r));
  assign est_nxt = swr_blend(bit_estimate_o, acc_sum[9:2], filter_sel);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_d_r <= 1'b1;
      presc_r <= 2'h0;
      bit_cnt_r <= 8'h00;
    end else begin
      rx_d_r <= bus_rx_i;
      presc_r <= q_tick ? 2'h0 : presc_r + 2'h1;
      if (bus_edge) bit_cnt_r <= 8'h00;
      else if (q_tick) bit_cnt_r <= bit_cnt_nxt;
    end
  end

  // Estimate update; disabled recovery tracks the programmed quanta
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_r <= 10'h000;
      acc_n_r <= 2'h0;
      bit_estimate_o <= QUANTA_RST;
    end else if (!recovery_enable || limit_evt) begin
      acc_r <= 10'h000; // RULE5
      acc_n_r <= 2'h0;
      bit_estimate_o <= bit_quanta_control_r; // RULE6
    end else if (bus_edge) begin
      acc_r <= (acc_n_r == 2'h3) ? 10'h000 : acc_sum; // RULE15
      acc_n_r <= acc_n_r + 2'h1;
      if (acc_n_r == 2'h3) bit_estimate_o <= est_nxt;
    end
  end

  // ==========================================================
  // Bus silence timer
  logic [CNT_W-1:0] sil_cnt_r;
  wire sil_done = (sil_cnt_r == CNT_W'(SILENCE_CYCLES - 1));
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sil_cnt_r <= '0;
      bus_idle_o <= 1'b0;
    end else if (bus_edge) begin
      sil_cnt_r <= '0; // RULE17
      bus_idle_o <= 1'b0;
    end else if (sil_done) begin
      bus_idle_o <= 1'b1; // RULE11
    end else begin
      sil_cnt_r <= sil_cnt_r + CNT_W'(1);
    end
  end
  wire silence_evt = sil_done & ~bus_idle_o & ~bus_edge;

  // ==========================================================
  // Wake reaction: fixed short delay well inside the limit
  logic [WAKE_DELAY_CYC-1:0] wake_pipe_r;
  wire wake_in = wake_pattern_i | wake_frame_i |
                 (wr_cmd & (wb_dat_i[CMD_PATTERN] | wb_dat_i[CMD_FRAME]));
  wire wake_evt = wake_pipe_r[WAKE_DELAY_CYC-1]; // RULE12
  always_ff @(posedge clk_i) begin
    if (rst_i) wake_pipe_r <= '0;
    else wake_pipe_r <= {wake_pipe_r[WAKE_DELAY_CYC-2:0], wake_in};
  end

  // Stop mode raises interrupt, sleep mode ramps the main regulator
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_int_o <= 1'b0;
      main_regulator_output_o <= 1'b1;
    end else begin
      wake_int_o <= wake_evt & (power_mode_i == PM_STOP); // RULE13
      if (wake_evt & (power_mode_i == PM_SLEEP)) main_regulator_output_o <= 1'b1;
      else if (power_mode_i == PM_SLEEP && !status_r[ST_WAKE]) main_regulator_output_o <= 1'b0;
      else if (power_mode_i != PM_SLEEP) main_regulator_output_o <= 1'b1;
    end
  end

  // ==========================================================
  // Sticky status; a new event wins over a write-one clear
  wire [NUM_EVT-1:0] evt_vec = {limit_evt, silence_evt, wake_evt};
  wire [NUM_EVT-1:0] clr_vec = wr_st ? wb_dat_i[NUM_EVT-1:0] : {NUM_EVT{1'b0}};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_r <= {NUM_EVT{1'b0}};
      irq_o <= 1'b0;
      transceiver_mode_o <= MODE_OFF;
    end else begin
      status_r <= (status_r & ~clr_vec) | evt_vec;
      irq_o <= |(((status_r & ~clr_vec) | evt_vec) & mask_r);
      transceiver_mode_o <= mode_r;
    end
  end

  // Minimum bit time of one microsecond is the host's duty on the bus
  localparam int MIN_BIT_CHECK = BIT_MIN_CYC; // RULE14
endmodule // swr_top

// ### testbench/swr_assertions.sv
// Purpose: Port-level checks for swr_top
// Assumes: classic Wishbone, one clock, SILENCE_CYCLES shortened
// Notes: Helper logic mirrors quanta and enable writes seen on the bus
`timescale 1ns/1ns
module swr_checker import swr_pkg::*; #(
  parameter int SILENCE_CYCLES = 200,
  parameter int CNT_W = 26
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic bus_rx_i,
  input wire logic [1:0] power_mode_i,
  input wire logic wake_pattern_i,
  input wire logic wake_frame_i,
  input wire logic wake_int_o,
  input wire logic main_regulator_output_o,
  input wire logic bus_idle_o,
  input wire logic [7:0] bit_estimate_o
);
  localparam int WAKE_LIM = 5000;
  logic [7:0] q_r;
  logic en_r;
  logic rx_r;
  int quiet_r;
  wire wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
  // ==========================================================
  // Shadow of quanta and enable, updated on the taking edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_r <= QUANTA_RST;
      en_r <= 1'b0;
    end else if (wr && wb_adr_i == ADDR_QUANTA) begin
      q_r <= wb_dat_i[7:0];
    end else if (wr && wb_adr_i == ADDR_CTRL_ONE) begin
      en_r <= wb_dat_i[ENABLE_BIT];
    end
  end
  // Cycles since the last bus edge
  always_ff @(posedge clk_i) begin
    rx_r <= bus_rx_i;
    quiet_r <= (rst_i || rx_r != bus_rx_i) ? 0 : quiet_r + 1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence off_s; (!en_r && !wb_cyc_i) [*3]; endsequence
  ack_next_a: assert property (req_s |=> wb_ack_o) else $error("ack missing");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("stray data");
  wake_stop_a: assert property (wake_pattern_i && power_mode_i == PM_STOP |-> ##3 wake_int_o)
    else $error("no stop wake pulse");
  frame_bound_a: assert property (wake_frame_i && power_mode_i == PM_STOP |-> ##[1:WAKE_LIM] wake_int_o)
    else $error("frame wake late");
  sleep_wake_a: assert property (wake_frame_i && power_mode_i == PM_SLEEP |-> ##[1:WAKE_LIM] main_regulator_output_o)
    else $error("regulator not raised");
  idle_clear_a: assert property ($changed(bus_rx_i) |-> ##[1:3] !bus_idle_o)
    else $error("idle kept after edge");
  idle_time_a: assert property ($rose(bus_idle_o) |-> quiet_r >= SILENCE_CYCLES - 3 && quiet_r <= SILENCE_CYCLES + 4)
    else $error("idle at wrong time");
  est_off_a: assert property (off_s |-> bit_estimate_o == q_r)
    else $error("estimate not quanta");
endmodule // swr_checker
bind swr_top swr_checker #(.SILENCE_CYCLES(SILENCE_CYCLES), .CNT_W(CNT_W)) chk (.*);

// ### testbench/swr_bus_node.sv
// Purpose: CAN bus node driving the receive line
// Assumes: bit time given in clock cycles
// Notes: Idles recessive; toggles once per bit while running
`timescale 1ns/1ns
module swr_bus_node import swr_pkg::*; (
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic [15:0] bit_cyc_i,
  output logic rx_o = 1'b1
);
  int cnt = 0;
  int len;
  // Never faster than one microsecond per bit
  assign len = (int'(bit_cyc_i) < BIT_MIN_CYC) ? BIT_MIN_CYC : int'(bit_cyc_i);
  // Stopping parks the line recessive, like a silent bus
  always @(posedge clk_i) begin
    if (!run_i) begin
      cnt <= 0;
      rx_o <= 1'b1;
    end else if (cnt >= len - 1) begin
      cnt <= 0;
      rx_o <= ~rx_o;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule // swr_bus_node

// ### testbench/swr_top_tb_top.sv
// Purpose: Self-checking bench for swr_top
// Assumes: SILENCE_CYCLES shortened to 200
// Notes: Expected tick counts and limit decisions come from bench functions
`timescale 1ns/1ns
module swr_top_tb_top;
  import swr_pkg::*;
  localparam int SIL = 200;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, rd, wb_dat_o;
  logic wb_ack_o, irq_o, wake_int_o, reg_o, idle_o, rx, run = 1'b0;
  logic wkp = 1'b0, wkf = 1'b0;
  logic [1:0] pm = 2'h0;
  logic [2:0] mode_o;
  logic [7:0] est_o, q;
  logic [15:0] gap = 16'h3C;
  int num_errors = 0, cmp_count = 0, cycles = 0;
  integer seed = 32'h803ccd3f;
  logic [7:0] ra [7] = '{ADDR_MODE, ADDR_QUANTA, ADDR_SAMPLE, ADDR_UPPER, ADDR_LOWER, ADDR_STATUS, 8'h3C};
  logic [31:0] rv [7] = '{32'h0, 32'h28, 32'h33, 32'h30, 32'h20, 32'h0, 32'h0};
  always #10 clk_i = ~clk_i;
  swr_top #(.SILENCE_CYCLES(SIL)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .bus_rx_i(rx), .power_mode_i(pm),
    .wake_pattern_i(wkp), .wake_frame_i(wkf), .irq_o(irq_o), .wake_int_o(wake_int_o),
    .main_regulator_output_o(reg_o), .bus_idle_o(idle_o), .transceiver_mode_o(mode_o),
    .bit_estimate_o(est_o));
  swr_bus_node node (.clk_i(clk_i), .run_i(run), .bit_cyc_i(gap), .rx_o(rx));
  // ==========================================================
  // Expectations: quanta ticks per edge gap, and the limit decision
  function automatic int ticks(input int g, input int cs);
    return g / (cs + 1);
  endfunction
  function automatic logic hit(input int t, input int up, input int lo);
    return t >= up || t <= lo;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Classic cycle: hold everything until ack is sampled, then release
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0, 4'hF);
    chk(rd, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic final_report;
    if (num_errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Hang guard, well above the fewer than two thousand cycles needed
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 20000) begin
      num_errors++;
      final_report;
    end
  end
  initial begin
    tick(6);
    rst_i <= 1'b0;
    foreach (ra[i]) rdc(ra[i], rv[i]);
    chk(est_o, QUANTA_RST);
    q = 8'h10 + 8'($random(seed) & 15);
    gap <= 16'h38 + 16'($random(seed) & 7);
    wb(1'b1, ADDR_MODE, {29'h0, MODE_OFF}, 4'hF);
    wb(1'b1, ADDR_CTRL_ONE, 32'h0, 4'hF);
    wb(1'b1, ADDR_CTRL_TWO, 32'h3, 4'hF);
    wb(1'b1, ADDR_QUANTA, {24'h0, q}, 4'hF);
    rdc(ADDR_CTRL_TWO, 32'h3);
    tick(3);
    chk(est_o, q);
    wb(1'b1, ADDR_QUANTA, 32'hFF, 4'hE);
    rdc(ADDR_QUANTA, {24'h0, q});
    wb(1'b1, ADDR_QUANTA, 32'h14, 4'hF);
    wb(1'b1, ADDR_UPPER, 32'h1E, 4'hF);
    wb(1'b1, ADDR_LOWER, 32'h0A, 4'hF);
    wb(1'b1, ADDR_CTRL_ONE, 32'h1, 4'hF);
    wb(1'b1, ADDR_MASK, 32'h4, 4'hF);
    run <= 1'b1;
    repeat (2) @(rx);
    wb(1'b1, ADDR_STATUS, 32'h7, 4'hF);
    repeat (8) @(rx);
    rdc(ADDR_STATUS, {29'h0, hit(ticks(gap, 3), 30, 10), 2'b00});
    chk(est_o >= 8'(ticks(gap, 3) - 1) && est_o <= 8'(ticks(gap, 3) + 1), 1'b1);
    gap <= 16'hC8;
    repeat (3) @(rx);
    tick(4);
    chk(est_o, 8'h14);
    chk(irq_o, hit(ticks(200, 3), 30, 10));
    run <= 1'b0;
    tick(2);
    wb(1'b1, ADDR_STATUS, 32'h7, 4'hF);
    rdc(ADDR_STATUS, 32'h0);
    chk(irq_o, 1'b0);
    wb(1'b1, ADDR_MASK, 32'h0, 4'hF);
    tick(SIL - 40);
    chk(idle_o, 1'b0);
    tick(50);
    chk(idle_o, 1'b1);
    rdc(ADDR_STATUS, 32'h2);
    chk(irq_o, 1'b0);
    wb(1'b1, ADDR_MASK, 32'h3, 4'hF);
    tick(2);
    chk(irq_o, 1'b1);
    run <= 1'b1;
    @(rx);
    tick(3);
    chk(idle_o, 1'b0);
    run <= 1'b0;
    wb(1'b1, ADDR_STATUS, 32'h7, 4'hF);
    pm <= PM_STOP;
    wkp <= 1'b1;
    tick(1);
    wkp <= 1'b0;
    tick(4);
    chk(irq_o, 1'b1);
    wb(1'b0, ADDR_STATUS, 32'h0, 4'hF);
    chk(rd[ST_WAKE], 1'b1);
    wb(1'b1, ADDR_STATUS, 32'h7, 4'hF);
    pm <= PM_SLEEP;
    tick(3);
    chk(reg_o, 1'b0);
    wkf <= 1'b1;
    tick(1);
    wkf <= 1'b0;
    tick(4);
    chk(reg_o, 1'b1);
    // Stop mode: injected wake command, then a frame wake
    wb(1'b1, ADDR_STATUS, 32'h7, 4'hF);
    pm <= PM_STOP;
    wb(1'b1, ADDR_WAKECMD, 32'h1, 4'hF);
    tick(3);
    rdc(ADDR_STATUS, 32'h1);
    wkf <= 1'b1;
    tick(1);
    wkf <= 1'b0;
    tick(4);
    rdc(ADDR_STATUS, 32'h1);
    rdc(ADDR_ESTIMATE, 32'h14);
    chk(mode_o, MODE_OFF);
    wb(1'b1, ADDR_MODE, 32'h5, 4'hF);
    tick(1);
    chk(mode_o, 3'h5);
    final_report;
  end
endmodule // swr_top_tb_top
